// ==== rtl/fcc_pkg.sv ====
// package: register map, field positions and reset values of the flash clock/option block
package fcc_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS       = 8'h04;
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h08;
  localparam logic [7:0] ADDR_STATUS        = 8'h0c;
  localparam logic [7:0] ADDR_KEY_BASE      = 8'h10;  // eight words, 0x10..0x2c
  localparam logic [7:0] ADDR_KEY_LAST      = 8'h2c;

  // field positions
  localparam int DIVISOR_LOADED_FLAG_BIT     = 7;
  localparam int PRESCALE_BIT  = 6;
  localparam int DIV_MSB       = 5;
  localparam int BACKDOOR_ENABLE_BIT     = 7;
  localparam int NORED_BIT     = 6;
  localparam int KEY_ACCESS_ENABLE_BIT    = 5;
  localparam int CFG_MSB       = 7;
  localparam int CFG_LSB       = 5;

  // reset values and codes
  localparam logic [7:0] CLOCK_DIVIDER_RST = 8'h00;
  localparam logic [2:0] CONFIG_RST        = 3'h0;
  localparam logic [1:0] SEC_UNSECURED     = 2'h2;
  localparam logic [2:0] PRESCALE_COUNT    = 3'h7;  // divide by eight
  localparam int         KEY_BYTES         = 8;
endpackage

// ==== rtl/fcc_flash_ctrl.sv ====
// flash clock divider, option and configuration registers with backdoor key entry
//
// Summary of operation
// - divisor-loaded flag is read-only, cleared by reset, set by first divider write.
// - divider low seven bits readable always, written only once after reset.
// - erase and program blocked until divisor-loaded flag is set.
// - prescale bit picks bus clock or bus clock divided by eight.
// - selected input divided by six-bit divisor plus one gives flash clock.
// - each timing pulse is one flash clock period; operations count whole pulses.
// - option byte loaded from nonvolatile source during reset; here captured at the first enabled clock after reset release.
// - option bits 5..2 read zero; writes ignored; always readable.
// - backdoor disabled never unlocks security.
// - eight matching key bytes, ascending, unlock security until reset.
// - key writes from background debug are refused.
// - redirection-disable set turns vector redirection off.
// - only security code 1:0 means unsecured.
// - secure device blocks memory access from unsecured sources.
// - code forced to 1:0 after key match or full-blank check.
// - config bits 7..5 read/write; bits 4..0 read zero.
// - key-access set makes key writes compare bytes, else start a command.
// - clearing key-access ends entry; match unlocks until reset.
// - program or erase before divider written is ignored with access error.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module fcc_flash_ctrl (
  input  wire logic        clk_i,              // bus clock, 25 mhz
  input  wire logic        reset_n_i,          // async reset, active low
  input  wire logic        clk_en_i,           // freezes all state when low
  input  wire logic        psel_i,             // apb select
  input  wire logic        penable_i,          // apb enable
  input  wire logic        pwrite_i,           // apb direction
  input  wire logic [7:0]  paddr_i,            // apb byte address
  input  wire logic [31:0] pwdata_i,           // apb write data
  output logic      [31:0] prdata_o,           // apb read data
  output logic             pready_o,           // apb ready
  output logic             pslverr_o,          // apb error on unmapped address
  input  wire logic        bus_from_debug_i,   // access comes from background debug
  input  wire logic        bus_from_secure_i,  // access comes from secured memory code
  input  wire logic [7:0]  nonvolatile_option_byte_i, // option byte from flash array
  input  wire logic [63:0] backdoor_key_i,     // stored key, byte 0 in bits 7:0
  input  wire logic        blank_check_pass_i, // pulse: blank check found array erased
  input  wire logic        command_request_i,  // pulse: sequencer asks to program/erase
  output logic             command_grant_o,    // pulse: command accepted
  output logic             access_error_flag_o, // pulse: command refused before divider set
  output logic             key_cmd_start_o,    // pulse: key location write starts command
  output logic             flash_pulse_o,      // one-cycle pulse per flash clock period
  output logic             secure_o,           // device currently secure
  output logic             redirect_enable_o,  // vector redirection active
  output logic             memory_access_ok_o  // memory access permitted for current source
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  divider_r;
  logic [7:0]  options_r;
  logic        opt_loaded_r;
  logic [2:0]  config_r;
  logic [7:0]  key_bytes_r [fcc_pkg::KEY_BYTES];
  logic [3:0]  key_count_r;
  logic        key_order_ok_r;
  logic        prev_key_wr_r;
  logic [2:0]  prescale_r;
  logic [5:0]  div_count_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        grant_r;
  logic        accerr_r;
  logic        key_cmd_r;
  logic        pulse_r;
  logic        secure_r;
  logic        redirect_r;
  logic        mem_ok_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup_w      = psel_i & ~penable_i;
  wire wr_w         = setup_w & pwrite_i & clk_en_i;
  wire sel_div_w    = paddr_i == fcc_pkg::ADDR_CLOCK_DIVIDER;
  wire sel_opt_w    = paddr_i == fcc_pkg::ADDR_OPTIONS;
  wire sel_cfg_w    = paddr_i == fcc_pkg::ADDR_CONFIGURATION;
  wire sel_stat_w   = paddr_i == fcc_pkg::ADDR_STATUS;
  wire sel_key_w    = (paddr_i >= fcc_pkg::ADDR_KEY_BASE) &&
                      (paddr_i <= fcc_pkg::ADDR_KEY_LAST) && (paddr_i[1:0] == 2'h0);
  wire [2:0] key_idx_w = 3'(paddr_i[4:2] - fcc_pkg::ADDR_KEY_BASE[4:2]);
  wire mapped_w     = sel_div_w | sel_opt_w | sel_cfg_w | sel_stat_w | sel_key_w;

  wire divisor_loaded_flag_w      = divider_r[fcc_pkg::DIVISOR_LOADED_FLAG_BIT];
  wire backdoor_enable_w      = options_r[fcc_pkg::BACKDOOR_ENABLE_BIT];
  wire key_access_enable_w     = config_r[fcc_pkg::KEY_ACCESS_ENABLE_BIT - fcc_pkg::CFG_LSB];
  wire div_wr_w     = wr_w & sel_div_w & ~divisor_loaded_flag_w;
  wire cfg_wr_w     = wr_w & sel_cfg_w;
  wire key_wr_w     = wr_w & sel_key_w;
  // key bytes accepted only from secured code, never from debug
  wire key_src_ok_w = bus_from_secure_i & ~bus_from_debug_i;
  wire key_cmp_wr_w = key_wr_w & key_access_enable_w & backdoor_enable_w & key_src_ok_w;
  wire in_order_w   = ({1'b0, key_idx_w} == key_count_r) & ~prev_key_wr_r;
  wire new_key_access_enable_w = pwdata_i[fcc_pkg::KEY_ACCESS_ENABLE_BIT];
  wire end_entry_w  = cfg_wr_w & key_access_enable_w & ~new_key_access_enable_w;

  logic key_match_w;
  always_comb begin
    key_match_w = 1'b1;
    for (int i = 0; i < fcc_pkg::KEY_BYTES; i++) begin
      if (key_bytes_r[i] != backdoor_key_i[8*i +: 8]) begin
        key_match_w = 1'b0;
      end
    end
  end

  wire unlock_w = (end_entry_w & backdoor_enable_w & key_order_ok_r &
                   (key_count_r == 4'(fcc_pkg::KEY_BYTES)) & key_match_w)
                  | (blank_check_pass_i & clk_en_i);
  wire cur_secure_w = options_r[1:0] != fcc_pkg::SEC_UNSECURED;

  wire [31:0] rd_div_w  = {24'h0, divider_r};
  wire [31:0] rd_opt_w  = {24'h0, options_r[7:6], 4'h0, options_r[1:0]};
  wire [31:0] rd_cfg_w  = {24'h0, config_r, 5'h00};
  wire [31:0] rd_stat_w = {28'h0, key_count_r};

  wire [31:0] rd_mux_w =
    sel_div_w  ? rd_div_w  :
    sel_opt_w  ? rd_opt_w  :
    sel_cfg_w  ? rd_cfg_w  :
    sel_stat_w ? rd_stat_w :
    32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: no wait states, answer in the first access-phase cycle
  wire        pready_nxt  = setup_w;
  wire        pslverr_nxt = setup_w & ~mapped_w;
  wire [31:0] prdata_nxt  = (setup_w & ~pwrite_i) ? rd_mux_w : 32'h0;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_r <= 1'b0;
    end else if (clk_en_i) begin
      pready_r <= pready_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error response on unmapped address
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pslverr_r <= 1'b0;
    end else if (clk_en_i) begin
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, zero outside the access phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h0;
    end else if (clk_en_i) begin
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock divider register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      divider_r <= fcc_pkg::CLOCK_DIVIDER_RST;
    end else if (div_wr_w) begin
      divider_r <= {1'b1, pwdata_i[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option register: captured at the first clock after reset release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opt_loaded_r <= 1'b0;
    end else if (clk_en_i) begin
      opt_loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      options_r <= 8'h00;
    end else if (clk_en_i) begin
      if (!opt_loaded_r) begin
        options_r <= nonvolatile_option_byte_i;
      end else if (unlock_w) begin
        options_r[1:0] <= fcc_pkg::SEC_UNSECURED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register and key entry
  wire entry_start_w = cfg_wr_w & new_key_access_enable_w & ~key_access_enable_w;
  wire count_step_w  = key_cmp_wr_w & in_order_w &
                       (key_count_r < 4'(fcc_pkg::KEY_BYTES));
  wire order_break_w = key_cmp_wr_w & ~count_step_w;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_r <= fcc_pkg::CONFIG_RST;
    end else if (cfg_wr_w) begin
      config_r <= pwdata_i[fcc_pkg::CFG_MSB:fcc_pkg::CFG_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key entry progress: adjacent key writes void the entry
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_key_wr_r <= 1'b0;
    end else if (clk_en_i && setup_w) begin
      prev_key_wr_r <= key_cmp_wr_w;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_count_r <= 4'h0;
    end else if (entry_start_w) begin
      key_count_r <= 4'h0;
    end else if (count_step_w) begin
      key_count_r <= 4'(key_count_r + 4'h1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_order_ok_r <= 1'b0;
    end else if (entry_start_w) begin
      key_order_ok_r <= 1'b1;
    end else if (order_break_w) begin
      key_order_ok_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key bytes as written
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < fcc_pkg::KEY_BYTES; i++) begin
        key_bytes_r[i] <= 8'h00;
      end
    end else if (key_cmp_wr_w) begin
      key_bytes_r[key_idx_w] <= pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash clock: prescaler then reloadable down-counter
  wire prescale_w  = divider_r[fcc_pkg::PRESCALE_BIT];
  wire tick_in_w   = ~prescale_w | (prescale_r == 3'h0);
  wire div_zero_w  = div_count_r == 6'h0;

  wire [2:0] prescale_nxt  = (prescale_r == 3'h0) ? fcc_pkg::PRESCALE_COUNT
                                                  : 3'(prescale_r - 3'h1);
  wire       pulse_nxt     = divisor_loaded_flag_w & tick_in_w & div_zero_w;
  wire [5:0] div_count_nxt = div_zero_w ? divider_r[fcc_pkg::DIV_MSB:0]
                                        : 6'(div_count_r - 6'h1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prescale_r <= fcc_pkg::PRESCALE_COUNT;
    end else if (clk_en_i) begin
      prescale_r <= prescale_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing pulse, one bus cycle wide
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_r <= 1'b0;
    end else if (clk_en_i) begin
      pulse_r <= pulse_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider stage, held at zero until the divisor is loaded
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_count_r <= 6'h0;
    end else if (clk_en_i) begin
      if (!divisor_loaded_flag_w) begin
        div_count_r <= 6'h0;
      end else if (tick_in_w) begin
        div_count_r <= div_count_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command gating and security outputs
  wire cmd_req_w = command_request_i & clk_en_i;

  wire grant_nxt    = cmd_req_w & divisor_loaded_flag_w;
  wire accerr_nxt   = cmd_req_w & ~divisor_loaded_flag_w;
  wire key_cmd_nxt  = key_wr_w & ~key_access_enable_w;
  wire secure_nxt   = cur_secure_w | ~opt_loaded_r;
  wire redirect_nxt = opt_loaded_r & ~options_r[fcc_pkg::NORED_BIT];
  wire mem_ok_nxt   = opt_loaded_r & (~cur_secure_w | key_src_ok_w);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_r <= 1'b0;
    end else if (clk_en_i) begin
      grant_r <= grant_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accerr_r <= 1'b0;
    end else if (clk_en_i) begin
      accerr_r <= accerr_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_cmd_r <= 1'b0;
    end else if (clk_en_i) begin
      key_cmd_r <= key_cmd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // security state seen by the rest of the device
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      secure_r <= 1'b1;
    end else if (clk_en_i) begin
      secure_r <= secure_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      redirect_r <= 1'b0;
    end else if (clk_en_i) begin
      redirect_r <= redirect_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ok_r <= 1'b0;
    end else if (clk_en_i) begin
      mem_ok_r <= mem_ok_nxt;
    end
  end

  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign command_grant_o     = grant_r;
  assign access_error_flag_o = accerr_r;
  assign key_cmd_start_o     = key_cmd_r;
  assign flash_pulse_o       = pulse_r;
  assign secure_o            = secure_r;
  assign redirect_enable_o   = redirect_r;
  assign memory_access_ok_o  = mem_ok_r;

endmodule

// ==== verification/fcc_flash_ctrl_asserts.sv ====
// concurrent checks on the flash clock, option and configuration block ports
`timescale 1ns/100ps
module fcc_flash_ctrl_asserts (
  input wire logic        clk_i, reset_n_i, clk_en_i,           // clock, reset, enable
  input wire logic        psel_i, penable_i, pwrite_i,          // apb control
  input wire logic [7:0]  paddr_i,                              // apb address
  input wire logic [31:0] prdata_o,                             // apb read data
  input wire logic        pready_o, pslverr_o,                  // apb answer
  input wire logic        command_request_i, command_grant_o,   // command handshake
  input wire logic        access_error_flag_o, flash_pulse_o,   // refusal, timing pulse
  input wire logic        secure_o, redirect_enable_o           // option state
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic loaded_r;
  wire  setup  = clk_en_i && psel_i && !penable_i;
  wire  rd_end = pready_o && !pwrite_i;
  wire  div_wr = setup && pwrite_i && paddr_i == fcc_pkg::ADDR_CLOCK_DIVIDER;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) loaded_r <= 1'b0;
    else if (div_wr) loaded_r <= 1'b1;
  end
  property p_grant; command_request_i && clk_en_i && loaded_r
    |=> command_grant_o && !access_error_flag_o; endproperty
  property p_refuse; command_request_i && clk_en_i && !loaded_r
    |=> access_error_flag_o && !command_grant_o; endproperty
  property p_ready; setup |=> pready_o ##1 !pready_o; endproperty
  property p_nostray; pready_o |-> psel_i && penable_i; endproperty
  property p_slverr; pready_o && paddr_i > fcc_pkg::ADDR_KEY_LAST |-> pslverr_o; endproperty
  property p_idle; !pready_o |-> prdata_o == 32'h0 && !pslverr_o; endproperty
  property p_opt; rd_end && paddr_i == fcc_pkg::ADDR_OPTIONS |-> prdata_o[5:2] == 4'h0
    && secure_o == (prdata_o[1:0] != fcc_pkg::SEC_UNSECURED)
    && redirect_enable_o == !prdata_o[6]; endproperty
  property p_cfg; rd_end && paddr_i == fcc_pkg::ADDR_CONFIGURATION
    |-> prdata_o[4:0] == 5'h0 && prdata_o[31:8] == 24'h0; endproperty
  property p_div; rd_end && paddr_i == fcc_pkg::ADDR_CLOCK_DIVIDER
    |-> prdata_o[7] == loaded_r; endproperty
  property p_nopulse; !loaded_r |-> !flash_pulse_o; endproperty
  a_grant:   assert property (p_grant) else $error("grant missing");
  a_refuse:  assert property (p_refuse) else $error("refusal missing");
  a_ready:   assert property (p_ready) else $error("ready timing");
  a_nostray: assert property (p_nostray) else $error("stray ready");
  a_slverr:  assert property (p_slverr) else $error("unmapped not flagged");
  a_idle:    assert property (p_idle) else $error("data outside access");
  a_opt:     assert property (p_opt) else $error("option readback");
  a_cfg:     assert property (p_cfg) else $error("config readback");
  a_div:     assert property (p_div) else $error("loaded flag readback");
  a_nopulse: assert property (p_nopulse) else $error("early flash pulse");
  c_grant:   cover property (command_grant_o);
  c_refuse:  cover property (access_error_flag_o);
  c_slverr:  cover property (pready_o && pslverr_o);
endmodule
bind fcc_flash_ctrl fcc_flash_ctrl_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .command_request_i(command_request_i), .command_grant_o(command_grant_o),
  .access_error_flag_o(access_error_flag_o), .flash_pulse_o(flash_pulse_o),
  .secure_o(secure_o), .redirect_enable_o(redirect_enable_o));

// ==== verification/fcc_flash_model.sv ====
// flash array side: option byte, stored key, sequencer requests
`timescale 1ns/100ps
module fcc_flash_model (
  input  wire logic  clk_i,   // bus clock
  output logic [7:0] opt_o,   // nonvolatile option byte
  output logic [63:0] key_o,  // stored backdoor key
  output logic       req_o,   // program/erase request pulse
  output logic       blank_o  // blank check passed pulse
);
  localparam logic [63:0] STORED_KEY = 64'h0123456789abcdef; // arbitrary value
  logic [7:0] opt = 8'h81;
  assign opt_o = opt;
  assign key_o = STORED_KEY;
  initial begin
    req_o = 1'b0;
    blank_o = 1'b0;
  end
  task pulse(input logic blank);
    @(posedge clk_i);
    if (blank) blank_o <= 1'b1;
    else req_o <= 1'b1;
    @(posedge clk_i);
    blank_o <= 1'b0;
    req_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the flash clock, option and configuration block
`timescale 1ns/100ps
module tb;
  logic clk_i, reset_n_i, psel_i, penable_i, pwrite_i, dbg, ssrc, err;
  logic [7:0]  paddr_i, opt;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [63:0] key;
  logic pready_o, pslverr_o, req, blank, grant, aerr, kcs, fpulse, secure, redir, mok;
  int miscompares = 0, total_checks = 0, n_grant = 0, n_err = 0, n_kcs = 0, per;
  fcc_flash_model m (.clk_i(clk_i), .opt_o(opt), .key_o(key), .req_o(req), .blank_o(blank));
  fcc_flash_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bus_from_debug_i(dbg), .bus_from_secure_i(ssrc), .nonvolatile_option_byte_i(opt),
    .backdoor_key_i(key), .blank_check_pass_i(blank), .command_request_i(req),
    .command_grant_o(grant), .access_error_flag_o(aerr), .key_cmd_start_o(kcs),
    .flash_pulse_o(fpulse), .secure_o(secure), .redirect_enable_o(redir),
    .memory_access_ok_o(mok));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_grant <= n_grant + (grant === 1'b1);
    n_err <= n_err + (aerr === 1'b1);
    n_kcs <= n_kcs + (kcs === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task rst(input logic [7:0] o);
    m.opt = o;
    reset_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task keys(input logic d);
    dbg <= d;
    ssrc <= 1'b1;
    apb(1'b1, fcc_pkg::ADDR_CONFIGURATION, 32'h20);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, fcc_pkg::ADDR_KEY_BASE + 8'(4 * i), {24'h0, key[8*i +: 8]});
      apb(1'b0, fcc_pkg::ADDR_STATUS, 32'h0);
    end
    apb(1'b1, fcc_pkg::ADDR_CONFIGURATION, 32'h0);
    dbg <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task period(output int n);
    n = 0;
    while (fpulse !== 1'b1 && n < 500) begin @(posedge clk_i); n++; end
    n = 0;
    do begin @(posedge clk_i); n++; end while (fpulse !== 1'b1 && n < 500);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, dbg, ssrc} = 6'h0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    for (int i = 0; i < 4; i++) begin
      rst({1'b1, i[0], 4'hf, i[1:0]});
      rd_chk(fcc_pkg::ADDR_OPTIONS, {24'h0, 1'b1, i[0], 4'h0, i[1:0]});
      chk(secure, i != 2);
      chk(redir, !i[0]);
      chk(mok, i == 2);
    end
    rst(8'h81);
    m.pulse(1'b0);
    chk(n_err, 1);
    apb(1'b1, fcc_pkg::ADDR_OPTIONS, 32'hff);
    rd_chk(fcc_pkg::ADDR_OPTIONS, 32'h81);
    apb(1'b1, fcc_pkg::ADDR_CONFIGURATION, 32'hffffffff);
    rd_chk(fcc_pkg::ADDR_CONFIGURATION, 32'he0);
    apb(1'b1, fcc_pkg::ADDR_CONFIGURATION, 32'h0);
    apb(1'b1, fcc_pkg::ADDR_KEY_BASE, 32'h5a);
    repeat (2) @(posedge clk_i);
    chk(n_kcs, 1);
    rd_chk(fcc_pkg::ADDR_CLOCK_DIVIDER, 32'h0);
    apb(1'b1, fcc_pkg::ADDR_CLOCK_DIVIDER, 32'h50);
    apb(1'b1, fcc_pkg::ADDR_CLOCK_DIVIDER, 32'h45);
    rd_chk(fcc_pkg::ADDR_CLOCK_DIVIDER, 32'hd0);
    period(per);
    chk(per, 136);
    m.pulse(1'b0);
    chk(n_grant, 1);
    keys(1'b1);
    chk(secure, 1'b1);
    chk(mok, 1'b1);
    keys(1'b0);
    rd_chk(fcc_pkg::ADDR_OPTIONS, 32'h82);
    chk(secure, 1'b0);
    rst(8'h01);
    apb(1'b1, fcc_pkg::ADDR_CLOCK_DIVIDER, 32'h53);
    period(per);
    chk(per, 160);
    keys(1'b0);
    chk(secure, 1'b1);
    m.pulse(1'b1);
    chk(secure, 1'b0);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1'b1);
    final_report;
  end
  initial begin
    #(40 * 20000);
    miscompares++;
    final_report;
  end
endmodule
